// ===== design/sbs_top.v
// Serial bus status flags and slave address mask, Wishbone classic slave.
// Assumes scl/sda pins asynchronous; controller core supplies event pulses.
//
// Notes on behaviour
// - Ack slot end records NACK as one
// - Master transmit flag spans byte plus ack
// - Collision flag sticky until software clears
// - General call flag set on match, cleared at stop
// - Ten-bit match flag set, cleared at stop
// - Transmit write while busy rejected, flagged
// - Receive into full buffer flags overflow
// - Data/address flag: clear on matched address, set on data
// - Stop flag shows stop was last
// - Start flag shows start was last
// - Direction flag taken from address byte
// - Receive full set on load, cleared on read
// - Transmit full set on write, cleared on done
// - Unused status bits read zero
// - Mask bit one ignores that address bit; accept_all_mode_enable_i forces all mask bits to zero
// - Reserved addresses never match, except general call and the ten-bit upper byte
`timescale 1ns/10ps
`include "sbs_defs.vh"
module sbs_top #(
    parameter MW = `SBS_MASK_W
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    // Wishbone classic
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [3:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Bus pins, sampled only
    input  wire        scl_i,
    input  wire        sda_i,
    // Controller core events, same clock
    input  wire        busy_i,
    input  wire        ack_slot_end_i,
    input  wire        mtx_start_i,
    input  wire        collision_i,
    input  wire        tx_done_i,
    input  wire        rx_byte_i,
    input  wire [7:0]  rx_data_i,
    input  wire        addr_byte_i,
    input  wire        addr_second_i,
    input  wire        slave_tx_done_i,
    input  wire [9:0]  own_addr_i,
    input  wire        ten_bit_mode_i,
    input  wire        gc_enable_i,
    input  wire        accept_all_mode_enable_i,
    output reg  [7:0]  transmit_buffer_o,
    output reg         tx_load_o,
    output wire        addr_match_o,
    output wire [15:0] status_o
);
    wire scl_s;
    wire sda_s;
    sbs_sync u_scl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .pin_i(scl_i), .level_o(scl_s));
    sbs_sync u_sda (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .pin_i(sda_i), .level_o(sda_s));

    reg sda_d_r;
    always @(posedge clk_i) begin
        if (rst_i)
            sda_d_r <= 1'b1;
        else if (ce_i)
            sda_d_r <= sda_s;
    end
    wire start_det = ce_i & scl_s & sda_d_r & ~sda_s;
    wire stop_det  = ce_i & scl_s & ~sda_d_r & sda_s;

    reg [MW-1:0] mask_r;
    reg [7:0]    receive_buffer_r;
    reg [6:0]    first_r;
    reg          ack_result_flag_r;
    reg          master_tx_active_flag_r;
    reg          bus_collision_flag_r;
    reg          general_call_flag_r;
    reg          ten_bit_match_flag_r;
    reg          write_collision_flag_r;
    reg          receive_overflow_flag_r;
    reg          data_flag_r;
    reg          stop_flag_r;
    reg          start_flag_r;
    reg          rw_flag_r;
    reg          receive_full_flag_r;
    reg          transmit_full_flag_r;

    wire hi_match;
    wire m7;
    wire m10;
    sbs_match #(.MW(MW)) u_match (
        .first_i    (addr_byte_i ? rx_data_i[7:1] : first_r),
        .second_i   (rx_data_i),
        .own_i      (own_addr_i),
        .ten_i      (ten_bit_mode_i),
        .mask_i     (accept_all_mode_enable_i ? {MW{1'b0}} : mask_r),
        .hi_match_o (hi_match),
        .match7_o   (m7),
        .match10_o  (m10)
    );
    wire gc_hit   = addr_byte_i && gc_enable_i && rx_data_i == {`SBS_GC_ADDR, 1'b0};
    wire own7     = addr_byte_i && m7;
    wire own10    = addr_second_i && m10;
    assign addr_match_o = own7 | own10 | gc_hit | (addr_byte_i & hi_match);

    // Wishbone decode
    wire req     = cyc_i & stb_i & ~ack_o & ce_i;
    wire wr      = req & we_i;
    wire rd      = req & ~we_i;
    wire wr_stat = wr && adr_i == `SBS_ADR_STATUS && sel_i[0];
    wire wr_mask = wr && adr_i == `SBS_ADR_MASK;
    wire wr_tx   = wr && adr_i == `SBS_ADR_TXBUF && sel_i[0];
    wire rd_rx   = rd && adr_i == `SBS_ADR_RXBUF;
    wire tx_ok   = wr_tx & ~busy_i;

    assign status_o = {ack_result_flag_r, master_tx_active_flag_r, 3'b000,
                       bus_collision_flag_r, general_call_flag_r, ten_bit_match_flag_r,
                       write_collision_flag_r, receive_overflow_flag_r, data_flag_r,
                       stop_flag_r, start_flag_r, rw_flag_r,
                       receive_full_flag_r, transmit_full_flag_r};

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o                   <= 1'b0;
            dat_o                   <= 32'h0000_0000;
            mask_r                  <= `SBS_MASK_RST;
            receive_buffer_r        <= 8'h00;
            transmit_buffer_o       <= 8'h00;
            tx_load_o               <= 1'b0;
            first_r                 <= 7'h00;
            ack_result_flag_r       <= 1'b0;
            master_tx_active_flag_r <= 1'b0;
            bus_collision_flag_r    <= 1'b0;
            general_call_flag_r     <= 1'b0;
            ten_bit_match_flag_r    <= 1'b0;
            write_collision_flag_r  <= 1'b0;
            receive_overflow_flag_r <= 1'b0;
            data_flag_r             <= 1'b0;
            stop_flag_r             <= 1'b0;
            start_flag_r            <= 1'b0;
            rw_flag_r               <= 1'b0;
            receive_full_flag_r     <= 1'b0;
            transmit_full_flag_r    <= 1'b0;
        end else if (ce_i) begin
            ack_o     <= req;
            tx_load_o <= tx_ok;
            if (rd) begin
                case (adr_i)
                    `SBS_ADR_STATUS: dat_o <= {16'h0000, status_o};
                    `SBS_ADR_MASK:   dat_o <= {{(32-MW){1'b0}}, mask_r};
                    `SBS_ADR_RXBUF:  dat_o <= {24'h000000, receive_buffer_r};
                    `SBS_ADR_TXBUF:  dat_o <= {24'h000000, transmit_buffer_o};
                    default:         dat_o <= 32'h0000_0000;
                endcase
            end
            if (wr_mask) begin
                if (sel_i[0])
                    mask_r[7:0] <= dat_i[7:0];
                if (sel_i[1])
                    mask_r[MW-1:8] <= dat_i[MW-1:8];
            end
            if (addr_byte_i)
                first_r <= rx_data_i[7:1];

            if (ack_slot_end_i)
                ack_result_flag_r <= sda_s;

            // Start wins over end of ack when both fall in one cycle
            if (mtx_start_i)
                master_tx_active_flag_r <= 1'b1;
            else if (ack_slot_end_i)
                master_tx_active_flag_r <= 1'b0;

            // Software clears by writing zero; a set in the same cycle wins
            if (collision_i)
                bus_collision_flag_r <= 1'b1;
            else if (wr_stat && sel_i[1] && !dat_i[`SBS_B_BCL])
                bus_collision_flag_r <= 1'b0;

            if (gc_hit)
                general_call_flag_r <= 1'b1;
            else if (stop_det)
                general_call_flag_r <= 1'b0;

            if (own10)
                ten_bit_match_flag_r <= 1'b1;
            else if (stop_det)
                ten_bit_match_flag_r <= 1'b0;

            if (wr_tx && busy_i)
                write_collision_flag_r <= 1'b1;
            else if (wr_stat && !dat_i[`SBS_B_WCOL])
                write_collision_flag_r <= 1'b0;

            if (rx_byte_i && receive_full_flag_r && !rd_rx)
                receive_overflow_flag_r <= 1'b1;
            else if (wr_stat && !dat_i[`SBS_B_OVF])
                receive_overflow_flag_r <= 1'b0;

            if (own7 || own10 || gc_hit)
                data_flag_r <= 1'b0;
            else if ((rx_byte_i && !addr_byte_i && !addr_second_i) || slave_tx_done_i)
                data_flag_r <= 1'b1;

            if (stop_det) begin
                stop_flag_r  <= 1'b1;
                start_flag_r <= 1'b0;
            end else if (start_det) begin
                stop_flag_r  <= 1'b0;
                start_flag_r <= 1'b1;
            end

            if (addr_byte_i)
                rw_flag_r <= rx_data_i[0];

            // Byte moves to the buffer only when it is empty or read in the same cycle, so unread data survives
            if (rx_byte_i && (!receive_full_flag_r || rd_rx)) begin
                receive_buffer_r    <= rx_data_i;
                receive_full_flag_r <= 1'b1;
            end else if (rd_rx)
                receive_full_flag_r <= 1'b0;

            if (tx_ok) begin
                transmit_buffer_o    <= dat_i[7:0];
                transmit_full_flag_r <= 1'b1;
            end else if (tx_done_i)
                transmit_full_flag_r <= 1'b0;
        end
    end
endmodule // sbs_top

// ===== design/sbs_defs.vh
// Constants for the serial bus status and address mask block.
// Included by every design file of the block; definitions only.
`ifndef SBS_DEFS_VH
`define SBS_DEFS_VH

`define SBS_ADR_STATUS   4'h0
`define SBS_ADR_MASK     4'h4
`define SBS_ADR_RXBUF    4'h8
`define SBS_ADR_TXBUF    4'hc

`define SBS_B_ACK        15
`define SBS_B_MTX        14
`define SBS_B_BCL        10
`define SBS_B_GC         9
`define SBS_B_A10        8
`define SBS_B_WCOL       7
`define SBS_B_OVF        6
`define SBS_B_DA         5
`define SBS_B_STOP       4
`define SBS_B_START      3
`define SBS_B_RW         2
`define SBS_B_RBF        1
`define SBS_B_TBF        0

`define SBS_MASK_W       10
`define SBS_MASK_RST     10'h000
`define SBS_STAT_RST     16'h0000
`define SBS_GC_ADDR      7'h00
`define SBS_TEN_HI       5'h1e

`endif

// ===== design/sbs_sync.v
// Three-stage synchroniser with agreement filter for one bus pin.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/10ps
`include "sbs_defs.vh"
module sbs_sync (
    input  wire clk_i,
    input  wire rst_i,
    input  wire ce_i,
    input  wire pin_i,
    output reg  level_o
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_r    <= 1'b1;
            s2_r    <= 1'b1;
            s3_r    <= 1'b1;
            level_o <= 1'b1;
        end else if (ce_i) begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // Change is taken only when stages two and three agree
            if (s2_r == s3_r)
                level_o <= s3_r;
        end
    end
endmodule // sbs_sync

// ===== design/sbs_match.v
// Slave address comparator with per-bit mask and reserved address guard.
// Assumes the address byte(s) are stable when the compare is used.
`timescale 1ns/10ps
`include "sbs_defs.vh"
module sbs_match #(
    parameter MW = `SBS_MASK_W
) (
    input  wire [6:0]    first_i,
    input  wire [7:0]    second_i,
    input  wire [9:0]    own_i,
    input  wire          ten_i,
    input  wire [MW-1:0] mask_i,
    output wire          hi_match_o,
    output wire          match7_o,
    output wire          match10_o
);
    wire [9:0] cmp;
    genvar g;
    generate
        for (g = 0; g < 10; g = g + 1) begin : g_bit
            wire inc;
            if (g < 7) begin : g_lo
                assign inc = ten_i ? second_i[g] : first_i[g];
            end else if (g == 7) begin : g_mid
                assign inc = ten_i ? second_i[g] : 1'b0;
            end else begin : g_hi
                // Upper byte carries bits 9 and 8 in its two lowest address positions
                assign inc = first_i[g-8];
            end
            assign cmp[g] = mask_i[g] | (inc == own_i[g]);
        end
    endgenerate

    // Reserved addresses never give a seven-bit match, whatever the mask; the ten-bit upper byte check does not use this guard
    wire reserved = (first_i[6:3] == 4'h0) || (first_i[6:3] == 4'hf);
    assign match7_o   = !ten_i && !reserved && (&cmp[6:0]);
    assign hi_match_o = ten_i && (first_i[6:2] == `SBS_TEN_HI) && (&cmp[9:8]);
    assign match10_o  = hi_match_o && (&cmp[7:0]);
endmodule // sbs_match

// ===== bench/sbs_monitor.sv
// Concurrent checks on the ports of sbs_top, attached by bind.
// Assumes one clock domain, synchronous active-high reset, ce_i high.
`timescale 1ns/10ps
module sbs_monitor (
    input wire        clk_i,
    input wire        rst_i,
    input wire        ce_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [3:0]  adr_i,
    input wire [3:0]  sel_i,
    input wire        busy_i,
    input wire        mtx_start_i,
    input wire        collision_i,
    input wire        rx_byte_i,
    input wire        ack_o,
    input wire        tx_load_o,
    input wire [15:0] status_o
);
    wire take  = cyc_i && stb_i && !ack_o;
    wire tx_wr = take && we_i && sel_i[0] && (adr_i == 4'hc);
    wire rx_rd = take && !we_i && (adr_i == 4'h8);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_ack_answer: assert property (take |=> ack_o) else $error("request not answered");
    a_unused_zero: assert property (status_o[13:11] == 3'h0) else $error("unused bits set");
    a_coll_set: assert property (collision_i |=> status_o[10]) else $error("collision not flagged");
    a_coll_hold: assert property (status_o[10] && !(take && we_i && adr_i == 4'h0) |=> status_o[10])
        else $error("collision flag lost");
    a_mtx_set: assert property (mtx_start_i |=> status_o[14]) else $error("transmit flag not set");
    a_rx_full: assert property (rx_byte_i |=> status_o[1]) else $error("receive full not set");
    a_ovf_set: assert property (rx_byte_i && status_o[1] && !rx_rd |=> status_o[6])
        else $error("overflow not flagged");
    a_wcol_set: assert property (tx_wr && busy_i |=> status_o[7] && !tx_load_o)
        else $error("busy write not refused");
    a_tx_take: assert property (tx_wr && !busy_i |=> tx_load_o && status_o[0])
        else $error("transmit write not taken");
    a_start_stop: assert property (!(status_o[4] && status_o[3])) else $error("start and stop both set");
    cover property (tx_wr && busy_i);
    cover property (rx_byte_i && status_o[1]);
    cover property (collision_i);
endmodule // sbs_monitor

bind sbs_top sbs_monitor i_mon (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .busy_i,
    .mtx_start_i, .collision_i, .rx_byte_i, .ack_o, .tx_load_o, .status_o);

// ===== bench/sbs_bus_model.sv
// Far side of the two-wire bus: another master making start and stop.
// Lines idle high as with pull-ups; link half period is 24 ns.
`timescale 1ns/10ps
module sbs_bus_model (
    output reg scl_o,
    output reg sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task do_start;
        sda_o <= 1'b0;
        #24 scl_o <= 1'b0;
        #24;
    endtask
    // Clock stays low from do_start until do_stop, so no spurious condition appears
    task do_stop;
        sda_o <= 1'b0;
        #24 scl_o <= 1'b1;
        #24 sda_o <= 1'b1;
        #24;
    endtask
endmodule // sbs_bus_model

// ===== bench/tb_top.sv
// Self-checking bench for sbs_top: event table, then register and bus cases.
// Assumes sbs_bus_model drives the pins and sbs_monitor is bound.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, busy_i = 1'b0;
    logic        tbm = 1'b0, am = 1'b0;
    logic [3:0]  adr_i = 4'h0, sel_i = 4'h3;
    logic [31:0] dat_i = 32'h0, q;
    logic [7:0]  ev = 8'h00, rxd = 8'h00;
    logic [20:0] rows [0:10];
    wire  [31:0] dat_o;
    wire  [15:0] status_o;
    wire  [7:0]  txb;
    wire         ack_o, tx_load_o, addr_match_o, scl, sda;
    int          miscompares = 0, check_count = 0;
    always #2 clk_i = ~clk_i;
    sbs_bus_model i_sbs_bus_model (.scl_o(scl), .sda_o(sda));
    sbs_top i_sbs_top (.clk_i, .rst_i, .ce_i(1'b1), .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .scl_i(scl), .sda_i(sda), .busy_i, .ack_slot_end_i(ev[7]), .mtx_start_i(ev[6]),
        .collision_i(ev[5]), .tx_done_i(ev[4]), .rx_byte_i(ev[3]), .rx_data_i(rxd), .addr_byte_i(ev[2]),
        .addr_second_i(ev[0]), .slave_tx_done_i(ev[1]), .own_addr_i(10'h02a), .ten_bit_mode_i(tbm),
        .gc_enable_i(1'b1), .accept_all_mode_enable_i(1'b0), .transmit_buffer_o(txb), .tx_load_o,
        .addr_match_o, .status_o);
    task automatic wb(input [3:0] a, input w, input [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task st;
        wb(4'h0, 1'b0, 32'h0);
    endtask
    task automatic pulse(input [7:0] e, input [7:0] d);
        @(posedge clk_i);
        ev <= e;
        rxd <= d;
        @(posedge clk_i);
        // Match output is combinational, so it is taken while the event stands
        am = addr_match_o;
        ev <= 8'h00;
    endtask
    task report_and_stop;
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Rows: event pulses, byte, status bit, expected level; idle sda reads as NACK
    initial begin
        rows = '{{8'h40, 8'h00, 4'he, 1'b1}, {8'h80, 8'h00, 4'hf, 1'b1}, {8'h00, 8'h00, 4'he, 1'b0},
            {8'h20, 8'h00, 4'ha, 1'b1}, {8'h08, 8'h5a, 4'h1, 1'b1}, {8'h08, 8'ha5, 4'h6, 1'b1},
            {8'h04, 8'h55, 4'h2, 1'b1}, {8'h00, 8'h00, 4'h5, 1'b0}, {8'h02, 8'h00, 4'h5, 1'b1},
            {8'h04, 8'h54, 4'h2, 1'b0}, {8'h04, 8'h00, 4'h9, 1'b1}};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        st;
        `CHK("reset status", 32'h0, q)
        foreach (rows[i]) begin
            pulse(rows[i][20:13], rows[i][12:5]);
            st;
            `CHK("status bit", rows[i][0], q[rows[i][4:1]])
        end
        wb(4'h4, 1'b1, 32'hffffffff);
        wb(4'h4, 1'b0, 32'h0);
        `CHK("mask", 32'h3ff, q)
        pulse(8'h04, 8'hf8);
        `CHK("reserved", 1'b0, am)
        wb(4'h4, 1'b1, 32'h0);
        pulse(8'h04, 8'h56);
        `CHK("exact miss", 1'b0, am)
        wb(4'h4, 1'b1, 32'h1);
        pulse(8'h04, 8'h56);
        `CHK("masked hit", 1'b1, am)
        wb(4'h0, 1'b1, 32'h0);
        st;
        `CHK("clear", 32'h8202, q & 32'h8643)
        busy_i <= 1'b1;
        wb(4'hc, 1'b1, 32'h33);
        busy_i <= 1'b0;
        st;
        `CHK("busy write", 32'h80, q & 32'h81)
        wb(4'hc, 1'b1, 32'h3c);
        st;
        `CHK("tx byte", 8'h3c, txb)
        `CHK("tx full", 32'h81, q & 32'h81)
        pulse(8'h10, 8'h00);
        st;
        `CHK("tx done", 32'h80, q & 32'h81)
        wb(4'h8, 1'b0, 32'h0);
        `CHK("rx byte", 32'h5a, q)
        st;
        `CHK("rx read", 32'h0, q & 32'h2)
        wb(4'h2, 1'b0, 32'h0);
        `CHK("unmapped", 32'h0, q)
        // Ten-bit: wrong upper bits refused, then upper and second byte of own address
        tbm <= 1'b1;
        pulse(8'h04, 8'hf2);
        `CHK("ten-bit upper miss", 1'b0, am)
        pulse(8'h04, 8'hf0);
        `CHK("ten-bit upper hit", 1'b1, am)
        pulse(8'h01, 8'h2a);
        `CHK("ten-bit second hit", 1'b1, am)
        tbm <= 1'b0;
        st;
        `CHK("ten-bit flag", 32'h100, q & 32'h120)
        i_sbs_bus_model.do_start;
        repeat (8) @(posedge clk_i);
        st;
        `CHK("start", 32'h8, q & 32'h18)
        i_sbs_bus_model.do_stop;
        repeat (8) @(posedge clk_i);
        st;
        `CHK("stop", 32'h10, q & 32'h318)
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        st;
        `CHK("second reset", 32'h0, q)
        report_and_stop;
    end
    // Tests need well under a thousand cycles
    initial begin
        #20000;
        miscompares++;
        report_and_stop;
    end
endmodule // tb_top
